/* include/mbs_pkg.sv */
package mbs_pkg;

    // Clock and serial framing
    localparam int CLK_HZ     = 20_000_000;
    localparam int BAUD       = 19200;
    localparam int BIT_CYC    = (CLK_HZ + BAUD / 2) / BAUD;
    localparam int DATA_BITS  = 8;
    localparam int STOP_BITS  = 1;
    localparam int FRAME_BITS = 1 + DATA_BITS + STOP_BITS;

    // Message pacing; the request spacing is the master's to keep
    localparam int GAP_MS     = 20;
    localparam int GAP_CYC    = CLK_HZ / 1000 * GAP_MS;
    localparam int REQ_GAP_MS = 50;

    // Request and reply layout
    localparam logic [3:0]  REQ_LEN   = 4'h8;
    localparam logic [7:0]  FUNC_READ = 8'h03;
    localparam logic [4:0]  HEAD_LEN  = 5'h03;
    localparam logic [4:0]  TAIL_LEN  = 5'h02;
    localparam logic [15:0] CRC_INIT  = 16'hFFFF;
    localparam logic [15:0] CRC_POLY  = 16'hA001;

    // Holding register map, numbered from zero
    localparam logic [3:0]  REG_EPOCH_HI = 4'h4;
    localparam logic [3:0]  REG_EPOCH_LO = 4'h5;
    localparam logic [3:0]  REG_HEALTH   = 4'h9;
    localparam logic [3:0]  REG_SPEED    = 4'hA;
    localparam logic [3:0]  REG_DIR      = 4'hB;
    localparam logic [3:0]  REG_CURRENT  = 4'hC;
    localparam logic [4:0]  REG_COUNT    = 5'h0D;
    localparam logic [15:0] REG_RSVD_VAL = 16'h0000;

    // Value encodings of the status words
    localparam logic [15:0] HEALTH_OK         = 16'h0004;
    localparam logic [15:0] HEALTH_MOTOR_COMM = 16'h0003;
    localparam logic [15:0] DIR_STOPPED       = 16'h0000;
    localparam logic [15:0] DIR_FORWARD       = 16'h0001;
    localparam logic [15:0] DIR_REVERSE       = 16'h0003;
    localparam int          SPEED_PER_RPM     = 100;

endpackage

/* rtl/mbs_uart_rx.sv */
`timescale 1ns/1ps
module mbs_uart_rx #(
    parameter int BIT_CYC = mbs_pkg::BIT_CYC
) (
    // Clock, reset, enable
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // Serial pin
    input  wire logic       rxd,
    // Received character
    output logic [7:0]      rx_byte,
    output logic            rx_valid
);
    import mbs_pkg::*;

    localparam int CW = $clog2(BIT_CYC);

    typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_STOP} mbs_rx_state_t;

    mbs_rx_state_t  state;
    logic           rxd_meta;
    logic           rxd_sync;
    logic [CW-1:0]  cnt;
    logic [2:0]     bit_idx;
    logic [7:0]     shift;

    wire half_bit = (cnt == CW'(BIT_CYC / 2 - 1));
    wire full_bit = (cnt == CW'(BIT_CYC - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxd_meta <= 1'b1;
            rxd_sync <= 1'b1;
        end else if (ce) begin
            rxd_meta <= rxd;
            rxd_sync <= rxd_meta;
        end
    end

    // Sampled at mid-bit; a bad stop bit drops the character
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= R_IDLE;
            cnt      <= '0;
            bit_idx  <= 3'h0;
            shift    <= 8'h00;
            rx_byte  <= 8'h00;
            rx_valid <= 1'b0;
        end else if (ce) begin
            rx_valid <= 1'b0;
            cnt      <= cnt + CW'(1);
            case (state)
                R_IDLE: begin
                    cnt <= '0;
                    if (!rxd_sync) state <= R_START;
                end
                R_START: if (half_bit) begin
                    cnt     <= '0;
                    bit_idx <= 3'h0;
                    state   <= rxd_sync ? R_IDLE : R_DATA;
                end
                R_DATA: if (full_bit) begin
                    cnt     <= '0;
                    shift   <= {rxd_sync, shift[7:1]};
                    bit_idx <= bit_idx + 3'h1;
                    if (bit_idx == 3'h7) state <= R_STOP;
                end
                R_STOP: if (full_bit) begin
                    cnt      <= '0;
                    rx_byte  <= shift;
                    rx_valid <= rxd_sync;
                    state    <= R_IDLE;
                end
                default: state <= R_IDLE;
            endcase
        end
    end

endmodule

/* rtl/mbs_status_slave.sv */
`timescale 1ns/1ps
// Function
// RL1: Link runs 19200 baud, eight data bits
// RL2: One stop bit, no parity, no handshake
// RL3: Master keeps byte gaps within 20 ms
// RL4: Master spaces requests at least 50 ms
// RL5: Answer every good function 3 read; code drops a read of zero registers or one reaching past register 12
// RL6: Request is address, function, start, count, CRC
// RL7: Reply is address, function, bytecount, data, CRC
// RL8: Master polls slaves one at a time
// RL9: Registers from zero; unused ones read zero
// RL10: Registers 4 and 5 split epoch seconds
// RL11: Epoch seconds come from satellite time
// RL12: Master may watch register 5 change
// RL13: Register 9 health: 4 healthy, 3 fault
// RL14: Register 10 speed in hundredths RPM
// RL15: Register 11 direction: 0, 1 or 3
// RL16: Register 12 motor current in milliamps
// RL17: Answer only own configurable slave identifier
// RL18: Drop bad CRC or function, no reply
// RL19: Long silence ends frame, restart decoding
module mbs_status_slave #(
    parameter int GAP_CYC = mbs_pkg::GAP_CYC,
    parameter int BIT_CYC = mbs_pkg::BIT_CYC
) (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Serial pins
    input  wire logic        rxd,
    output logic             txd,
    // Configuration
    input  wire logic [7:0]  slave_id,
    // Status sources
    input  wire logic [31:0] gps_epoch_seconds,
    input  wire logic [15:0] health_code,
    input  wire logic [15:0] motor_speed,
    input  wire logic [15:0] motor_direction,
    input  wire logic [15:0] motor_current,
    // Activity
    output logic             reply_active,
    output logic             frame_taken,
    output logic             frame_dropped
);
    import mbs_pkg::*;

    // Silence is counted from the mid-stop strobe, so a legal stop-to-start gap
    // of a full GAP_CYC would split the frame; one character plus a bit of slack
    localparam int END_CYC = GAP_CYC + (FRAME_BITS + 1) * BIT_CYC;
    localparam int GW      = $clog2(END_CYC);
    localparam int BW = $clog2(BIT_CYC);

    typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_LOAD, ST_SHIFT} mbs_state_t;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    mbs_state_t     state;
    logic [7:0]     rx_buf [0:7];
    logic [3:0]     rx_cnt;
    logic           rx_ovf;
    logic [15:0]    rx_crc;
    logic [GW-1:0]  gap_cnt;
    logic [7:0]     rx_byte;
    logic           rx_valid;

    logic [3:0]     req_start;
    logic [4:0]     req_cnt;
    logic [31:0]    snap_epoch;
    logic [15:0]    snap_health;
    logic [15:0]    snap_speed;
    logic [15:0]    snap_dir;
    logic [15:0]    snap_current;

    logic [4:0]     tx_idx;
    logic [15:0]    tx_crc;
    logic [8:0]     tx_shift;
    logic [3:0]     tx_bit;
    logic [BW-1:0]  baud_cnt;

    mbs_uart_rx #(
        .BIT_CYC (BIT_CYC)
    ) u_rx (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .rxd      (rxd),
        .rx_byte  (rx_byte),
        .rx_valid (rx_valid)
    );

    // Request decode
    wire [15:0] req_addr_w  = {rx_buf[2], rx_buf[3]};
    wire [15:0] req_cnt_w   = {rx_buf[4], rx_buf[5]};
    wire [16:0] req_end_w   = {1'b0, req_addr_w} + {1'b0, req_cnt_w};
    wire        len_ok      = (rx_cnt == REQ_LEN) && !rx_ovf;                     // [RL6]
    wire        id_ok       = (rx_buf[0] == slave_id);                            // [RL17]
    wire        func_ok     = (rx_buf[1] == FUNC_READ);                           // [RL5] [RL18]
    wire        crc_ok      = (rx_crc == 16'h0000);                               // [RL18]
    wire        range_ok    = (req_cnt_w != 16'h0000) && (req_end_w <= {12'h000, REG_COUNT});
    wire        frame_good  = len_ok && id_ok && func_ok && crc_ok && range_ok;
    wire        gap_done    = (rx_cnt != 4'h0) && (gap_cnt == GW'(END_CYC - 1));  // [RL19]

    // Reply layout
    wire [4:0]  tx_last     = HEAD_LEN + {req_cnt[3:0], 1'b0} + TAIL_LEN - 5'h01;
    wire [4:0]  data_off    = tx_idx - HEAD_LEN;
    wire [3:0]  word_addr   = req_start + data_off[4:1];
    wire [7:0]  byte_count  = {2'b00, req_cnt, 1'b0};                             // [RL7]

    // Holding register view; unused numbers read as zero
    logic [15:0] reg_word;
    always_comb begin
        case (word_addr)
            REG_EPOCH_HI: reg_word = snap_epoch[31:16];                          // [RL10] [RL11]
            REG_EPOCH_LO: reg_word = snap_epoch[15:0];                           // [RL10] [RL11]
            REG_HEALTH:   reg_word = snap_health;                                // [RL13]
            REG_SPEED:    reg_word = snap_speed;                                 // [RL14]
            REG_DIR:      reg_word = snap_dir;                                   // [RL15]
            REG_CURRENT:  reg_word = snap_current;                               // [RL16]
            default:      reg_word = REG_RSVD_VAL;                               // [RL9]
        endcase
    end

    logic [7:0] tx_byte;
    always_comb begin
        if (tx_idx == 5'h00) begin
            tx_byte = slave_id;                                                   // [RL7]
        end else if (tx_idx == 5'h01) begin
            tx_byte = FUNC_READ;                                                  // [RL7]
        end else if (tx_idx == 5'h02) begin
            tx_byte = byte_count;
        end else if (tx_idx == tx_last - 5'h01) begin
            tx_byte = tx_crc[7:0];
        end else if (tx_idx == tx_last) begin
            tx_byte = tx_crc[15:8];
        end else begin
            tx_byte = data_off[0] ? reg_word[7:0] : reg_word[15:8];
        end
    end

    wire tx_in_crc  = (tx_idx >= tx_last - 5'h01);
    wire bit_end    = (baud_cnt == BW'(BIT_CYC - 1));                             // [RL1]
    wire char_end   = bit_end && (tx_bit == 4'(FRAME_BITS - 1));                  // [RL2]

    // Frame collection; the receiver is ignored while replying so an echo
    // on a shared line cannot start a bogus request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_cnt  <= 4'h0;
            rx_ovf  <= 1'b0;
            rx_crc  <= CRC_INIT;
            gap_cnt <= '0;
        end else if (ce) begin
            if (state == ST_CHECK) begin
                rx_cnt  <= 4'h0;                                                  // [RL19]
                rx_ovf  <= 1'b0;
                rx_crc  <= CRC_INIT;
                gap_cnt <= '0;
            end else if (state == ST_IDLE && rx_valid) begin
                gap_cnt <= '0;
                if (rx_cnt == REQ_LEN) begin
                    rx_ovf <= 1'b1;
                end else begin
                    rx_cnt <= rx_cnt + 4'h1;
                    rx_crc <= crc_step(rx_crc, rx_byte);
                end
            end else if (state == ST_IDLE && rx_cnt != 4'h0 && !gap_done) begin
                gap_cnt <= gap_cnt + GW'(1);
            end
        end
    end

    // Request bytes kept per position
    for (genvar g = 0; g < 8; g++) begin : g_buf
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                rx_buf[g] <= 8'h00;
            end else if (ce && state == ST_IDLE && rx_valid && rx_cnt == 4'(g)) begin
                rx_buf[g] <= rx_byte;
            end
        end
    end

    // Snapshot at acceptance keeps the two epoch halves coherent
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_start    <= 4'h0;
            req_cnt      <= 5'h00;
            snap_epoch   <= 32'h0000_0000;
            snap_health  <= 16'h0000;
            snap_speed   <= 16'h0000;
            snap_dir     <= 16'h0000;
            snap_current <= 16'h0000;
        end else if (ce && state == ST_CHECK && frame_good) begin
            req_start    <= req_addr_w[3:0];
            req_cnt      <= req_cnt_w[4:0];
            snap_epoch   <= gps_epoch_seconds;                                    // [RL11]
            snap_health  <= health_code;
            snap_speed   <= motor_speed;
            snap_dir     <= motor_direction;
            snap_current <= motor_current;
        end
    end

    // Control and transmitter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state         <= ST_IDLE;
            tx_idx        <= 5'h00;
            tx_crc        <= CRC_INIT;
            tx_shift      <= 9'h1FF;
            tx_bit        <= 4'h0;
            baud_cnt      <= '0;
            txd           <= 1'b1;
            reply_active  <= 1'b0;
            frame_taken   <= 1'b0;
            frame_dropped <= 1'b0;
        end else if (ce) begin
            frame_taken   <= 1'b0;
            frame_dropped <= 1'b0;
            case (state)
                ST_IDLE: begin
                    txd <= 1'b1;
                    if (gap_done && !rx_valid) state <= ST_CHECK;                 // [RL19]
                end
                ST_CHECK: begin
                    tx_idx <= 5'h00;
                    tx_crc <= CRC_INIT;
                    if (frame_good) begin
                        state        <= ST_LOAD;                                  // [RL5]
                        reply_active <= 1'b1;
                        frame_taken  <= 1'b1;
                    end else begin
                        state         <= ST_IDLE;                                 // [RL18]
                        frame_dropped <= 1'b1;
                    end
                end
                ST_LOAD: begin
                    txd      <= 1'b0;
                    tx_shift <= {1'b1, tx_byte};                                  // [RL2]
                    tx_bit   <= 4'h0;
                    baud_cnt <= '0;
                    if (!tx_in_crc) tx_crc <= crc_step(tx_crc, tx_byte);          // [RL7]
                    state    <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    baud_cnt <= bit_end ? '0 : baud_cnt + BW'(1);
                    if (char_end) begin
                        if (tx_idx == tx_last) begin
                            state        <= ST_IDLE;
                            reply_active <= 1'b0;
                        end else begin
                            tx_idx <= tx_idx + 5'h01;
                            state  <= ST_LOAD;
                        end
                    end else if (bit_end) begin
                        txd      <= tx_shift[0];                                  // [RL1]
                        tx_shift <= {1'b1, tx_shift[8:1]};
                        tx_bit   <= tx_bit + 4'h1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    a_idle_line_high: assert property (@(posedge clk) disable iff (!rst_n) // [RL2]
        state == ST_IDLE && !reply_active |-> txd)
        else $error("line not idle high between replies");

    a_start_bit_low: assert property (@(posedge clk) disable iff (!rst_n) // [RL1]
        ce && state == ST_LOAD |=> !txd && state == ST_SHIFT)
        else $error("character did not open with a start bit");

    a_reply_head_id: assert property (@(posedge clk) disable iff (!rst_n) // [RL17]
        ce && state == ST_CHECK && frame_good |=> state == ST_LOAD && tx_idx == 5'h00 && tx_byte == rx_buf[0])
        else $error("reply does not open with the own identifier");

    a_reply_func_code: assert property (@(posedge clk) disable iff (!rst_n) // [RL7]
        state == ST_LOAD && tx_idx == 5'h01 |-> tx_byte == rx_buf[1] && rx_buf[1] == FUNC_READ)
        else $error("second reply byte is not the read function");

    a_reply_byte_count: assert property (@(posedge clk) disable iff (!rst_n) // [RL7]
        state == ST_LOAD && tx_idx == 5'h02 |-> tx_byte == {rx_buf[5][6:0], 1'b0} && rx_buf[4] == 8'h00)
        else $error("byte count differs from twice the register count");

    a_bad_frame_drop: assert property (@(posedge clk) disable iff (!rst_n) // [RL18]
        ce && state == ST_CHECK && !frame_good |=> state == ST_IDLE && frame_dropped && !reply_active)
        else $error("rejected request still produced a reply");

    a_silence_ends_frame: assert property (@(posedge clk) disable iff (!rst_n) // [RL19]
        ce && state == ST_IDLE && gap_done && !rx_valid |=> state == ST_CHECK ##1 rx_cnt == 4'h0)
        else $error("silence did not close and clear the frame");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n) // [RL9]
        state == ST_LOAD && tx_idx > 5'h02 && !tx_in_crc && word_addr < REG_EPOCH_HI |-> tx_byte == 8'h00)
        else $error("unused register returned nonzero data");

    a_epoch_split: assert property (@(posedge clk) disable iff (!rst_n) // [RL10]
        state == ST_LOAD && !tx_in_crc && tx_idx > 5'h02 && word_addr == REG_EPOCH_LO && data_off[0]
        |-> tx_byte == snap_epoch[7:0])
        else $error("low epoch register holds wrong half");

    a_accept_pulse: assert property (@(posedge clk) disable iff (!rst_n) // [RL5]
        ce && state == ST_CHECK && frame_good |=> reply_active && frame_taken && !frame_dropped)
        else $error("accepted request did not start a reply");

    a_stop_bit_high: assert property (@(posedge clk) disable iff (!rst_n) // [RL2]
        state == ST_SHIFT && char_end |-> txd)
        else $error("character did not close with a stop bit");

    a_snapshot_epoch: assert property (@(posedge clk) disable iff (!rst_n) // [RL11]
        ce && state == ST_CHECK && frame_good |=> snap_epoch == $past(gps_epoch_seconds))
        else $error("epoch seconds not captured at acceptance");

    a_short_frame_drop: assert property (@(posedge clk) disable iff (!rst_n) // [RL6]
        ce && state == ST_CHECK && rx_cnt != REQ_LEN |=> frame_dropped && !reply_active)
        else $error("request of wrong length was not dropped");

    a_foreign_id_drop: assert property (@(posedge clk) disable iff (!rst_n) // [RL17]
        ce && state == ST_CHECK && rx_buf[0] != slave_id |=> frame_dropped && !reply_active)
        else $error("request for another identifier was not dropped");

    a_bad_crc_drop: assert property (@(posedge clk) disable iff (!rst_n) // [RL18]
        ce && state == ST_CHECK && !crc_ok |=> frame_dropped && !reply_active)
        else $error("request with a bad check word was not dropped");

    a_zero_count_drop: assert property (@(posedge clk) disable iff (!rst_n) // [RL5]
        ce && state == ST_CHECK && req_cnt_w == 16'h0000 |=> frame_dropped && !reply_active)
        else $error("request for no registers was not dropped");

    a_health_word: assert property (@(posedge clk) disable iff (!rst_n) // [RL13]
        state == ST_LOAD && tx_idx > 5'h02 && !tx_in_crc && word_addr == REG_HEALTH && !data_off[0]
        |-> tx_byte == snap_health[15:8])
        else $error("health register high byte wrong");

endmodule

/* testbench/mbs_master_model.sv */
`timescale 1ns/1ps
module mbs_master_model #(
    parameter int BIT_CYC = 16
) (
    // Clock
    input  wire logic clk,
    // Serial pins, seen from the master
    input  wire logic txd,
    output logic      rxd
);
    // Line idles high between characters
    initial rxd = 1'b1;

    // Start bit, eight data bits LSB first, one stop bit, no parity, no handshake
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] sh;
        sh = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            rxd <= sh[i];
            repeat (BIT_CYC - 1) @(posedge clk);
        end
    endtask

    // Gap is idle cycles after each stop bit but the last, at most the allowed inter-byte gap
    task automatic send_frame(input logic [7:0] q[$], input int gap);
        foreach (q[i]) begin
            if (i != 0) repeat (gap) @(posedge clk);
            send_byte(q[i]);
        end
    endtask

    // Sampled on the falling edge so the registered txd has settled; resyncs on every start bit
    task automatic recv_byte(input int limit, output logic [7:0] b, output bit ok);
        int n;
        n = 0;
        ok = 1'b0;
        b = 8'h00;
        while (txd !== 1'b0 && n < limit) begin
            @(negedge clk);
            n++;
        end
        if (txd === 1'b0) begin
            repeat (BIT_CYC / 2) @(negedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(negedge clk);
                b[i] = txd;
            end
            repeat (BIT_CYC) @(negedge clk);
            ok = (txd === 1'b1);
        end
    endtask
endmodule

/* testbench/mbs_status_slave_bench.sv */
`timescale 1ns/1ps
module mbs_status_slave_bench;
    import mbs_pkg::*;

    localparam int BIT_T     = 16;
    localparam int GAP_T     = 400;
    localparam int REQ_GAP_T = 1000;
    localparam int WAIT_T    = GAP_T + 40 * BIT_T;

    logic        clk;
    logic        rst_n;
    logic        ce;
    logic        rxd;
    logic        txd;
    logic [7:0]  slave_id;
    logic [31:0] epoch;
    logic [15:0] health;
    logic [15:0] speed;
    logic [15:0] dir;
    logic [15:0] current;
    logic        reply_active;
    logic        frame_taken;
    logic        frame_dropped;
    int          miscompares;
    int          cmp_count;
    int          taken_n;
    int          dropped_n;
    int          txd_low_n;
    int          byte_gap;
    logic [15:0] dirs [3];

    mbs_status_slave #(.GAP_CYC(GAP_T), .BIT_CYC(BIT_T)) i_mbs_status_slave (
        .clk(clk), .rst_n(rst_n), .ce(ce), .rxd(rxd), .txd(txd), .slave_id(slave_id),
        .gps_epoch_seconds(epoch), .health_code(health), .motor_speed(speed),
        .motor_direction(dir), .motor_current(current), .reply_active(reply_active),
        .frame_taken(frame_taken), .frame_dropped(frame_dropped)
    );

    mbs_master_model #(.BIT_CYC(BIT_T)) i_mbs_master_model (.clk(clk), .txd(txd), .rxd(rxd));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        if (frame_taken === 1'b1) taken_n++;
        if (frame_dropped === 1'b1) dropped_n++;
        if (txd !== 1'b1) txd_low_n++;
    end

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bail(input string what);
        miscompares++;
        $display("MISMATCH %s expected completion seen timeout", what);
        complete_run();
    endtask

    function automatic logic [15:0] reg_val(input int a);
        case (a)
            4: return epoch[31:16];
            5: return epoch[15:0];
            9: return health;
            10: return speed;
            11: return dir;
            12: return current;
            default: return REG_RSVD_VAL;
        endcase
    endfunction

    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = CRC_INIT;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
            end
        end
        return c;
    endfunction

    // One request, then either the whole reply byte by byte or silence
    task automatic transact(input logic [7:0] id, input logic [7:0] fn, input logic [15:0] start,
                            input logic [15:0] count, input bit bad_crc, input bit answer);
        logic [7:0]  q[$];
        logic [7:0]  r[$];
        logic [7:0]  b;
        logic [15:0] c;
        bit          ok;
        int          t0;
        int          d0;
        int          l0;
        int          n;
        t0 = taken_n;
        d0 = dropped_n;
        q = {id, fn, start[15:8], start[7:0], count[15:8], count[7:0]};
        c = crc16(q) ^ (bad_crc ? 16'h0001 : 16'h0000);
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        i_mbs_master_model.send_frame(q, byte_gap);
        l0 = txd_low_n;
        if (answer) begin
            r = {id, FUNC_READ, 8'(count << 1)};
            for (int a = int'(start); a < int'(start) + int'(count); a++) begin
                c = reg_val(a);
                r.push_back(c[15:8]);
                r.push_back(c[7:0]);
            end
            c = crc16(r);
            r.push_back(c[7:0]);
            r.push_back(c[15:8]);
            foreach (r[i]) begin
                i_mbs_master_model.recv_byte(WAIT_T, b, ok);
                if (!ok) bail("reply byte");
                check("reply byte", {8'h00, r[i]}, {8'h00, b});
            end
            n = 0;
            while (reply_active !== 1'b0 && n < WAIT_T) begin
                @(negedge clk);
                n++;
            end
            if (n == WAIT_T) bail("reply end");
            check("taken", 16'(t0 + 1), 16'(taken_n));
        end else begin
            repeat (WAIT_T) @(negedge clk);
            check("dropped", 16'(d0 + 1), 16'(dropped_n));
            check("silent line", 16'(l0), 16'(txd_low_n));
        end
        // Master keeps request spacing; design does not police it
        repeat (REQ_GAP_T) @(posedge clk);
    endtask

    task automatic set_status(input logic [31:0] e, input logic [15:0] h, input logic [15:0] d);
        @(posedge clk);
        epoch <= e;
        health <= h;
        dir <= d;
        @(posedge clk);
    endtask

    initial begin
        logic [7:0] q[$];
        int         d0;
        rst_n = 1'b0;
        ce = 1'b1;
        slave_id = 8'h21;
        epoch = 32'h5A3C_0F12;
        health = HEALTH_OK;
        speed = 16'h2710;
        dir = DIR_FORWARD;
        current = 16'h0320;
        miscompares = 0;
        cmp_count = 0;
        taken_n = 0;
        dropped_n = 0;
        txd_low_n = 0;
        byte_gap = 0;
        dirs = '{DIR_STOPPED, DIR_FORWARD, DIR_REVERSE};
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        transact(slave_id, FUNC_READ, 16'h0004, 16'h0002, 1'b0, 1'b1);
        byte_gap = GAP_T;
        transact(slave_id, FUNC_READ, 16'h0009, 16'h0004, 1'b0, 1'b1);
        byte_gap = 0;
        transact(slave_id, FUNC_READ, 16'h0000, 16'h000D, 1'b0, 1'b1);
        foreach (dirs[i]) begin
            set_status(epoch + 32'h0001_0001, (i == 1) ? HEALTH_MOTOR_COMM : HEALTH_OK, dirs[i]);
            transact(slave_id, FUNC_READ, 16'h0005, 16'h0007, 1'b0, 1'b1);
        end
        transact(8'h22, FUNC_READ, 16'h0004, 16'h0002, 1'b0, 1'b0);
        transact(slave_id, FUNC_READ, 16'h0004, 16'h0002, 1'b1, 1'b0);
        transact(slave_id, 8'h04, 16'h0004, 16'h0002, 1'b0, 1'b0);
        transact(slave_id, FUNC_READ, 16'h0004, 16'h0000, 1'b0, 1'b0);
        transact(slave_id, FUNC_READ, 16'h000C, 16'h0002, 1'b0, 1'b0);
        transact(slave_id, FUNC_READ, 16'h000C, 16'h0001, 1'b0, 1'b1);
        // Truncated request, silence, then a full one must still decode
        d0 = dropped_n;
        q = {slave_id, FUNC_READ, 8'h00};
        i_mbs_master_model.send_frame(q, 0);
        repeat (WAIT_T) @(negedge clk);
        check("partial dropped", 16'(d0 + 1), 16'(dropped_n));
        transact(slave_id, FUNC_READ, 16'h0009, 16'h0001, 1'b0, 1'b1);
        @(posedge clk);
        slave_id <= 8'h5B;
        @(posedge clk);
        transact(8'h5B, FUNC_READ, 16'h000A, 16'h0003, 1'b0, 1'b1);
        transact(8'h21, FUNC_READ, 16'h000A, 16'h0003, 1'b0, 1'b0);
        complete_run();
    end
endmodule
